// *** core/ctd_core.sv ***
// Fetch, decode and execute of the test, transfer and addressing-mode instructions.
`timescale 1ns/1ps
`default_nettype none
module ctd_core (
    // Clock, reset and enable.
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic CE,
    // Memory bus; read data must be valid in the same cycle that the read request is shown on MEM_REQ.
    output ctd_pkg::ctd_mem_req_s MEM_REQ,
    input wire logic [7:0] MEM_RDATA,
    // Register file view and status.
    output ctd_pkg::ctd_regs_s REGS,
    output logic ILLEGAL
);
    import ctd_pkg::*;

    typedef enum logic [2:0] {
        S_FETCH, S_OPC, S_OPR, S_OPRD, S_ADDR, S_DATA, S_XFER
    } ctd_state_e;

    typedef struct packed {
        ctd_state_e st;
        ctd_regs_s rg;
        ctd_mem_req_s mem;
        logic pre;
        ctd_dec_s dec;
        logic [1:0] cnt;
        logic [7:0] ob0;
        logic [7:0] ob1;
        logic ill;
    } ctd_state_s;

    localparam ctd_state_s STATE_RESET = '{
        st: S_FETCH,
        rg: '{PC_RESET, SP_RESET, 16'h0000, 8'h00, FLAGS_RESET},
        mem: '{16'h0000, 1'b0, 1'b0, 8'h00},
        pre: 1'b0,
        dec: '{K_ILL, M_INH, 2'd0},
        cnt: 2'd0,
        ob0: 8'h00,
        ob1: 8'h00,
        ill: 1'b0
    };

    ctd_state_s r;
    ctd_state_s next_r;

    function automatic logic [7:0] nz_flags(input logic [7:0] f, input logic [7:0] v);
        logic [7:0] o;
        o = f;
        o[FLAG_V] = 1'b0;
        o[FLAG_N] = v[7];
        o[FLAG_Z] = (v == 8'h00);
        return o;
    endfunction

    function automatic logic [15:0] eff_addr(input ctd_mode_e m, input logic [7:0] b0,
        input logic [7:0] b1, input logic [15:0] hx, input logic [15:0] sp);
        logic [15:0] ea;
        case (m)
            M_EXT: ea = {b0, b1};
            M_IX, M_IXP, M_IXPD: ea = hx;
            M_IX1, M_IX1P: ea = 16'(hx + {8'h00, b0});
            M_IX2: ea = 16'(hx + {b0, b1});
            M_SP1: ea = 16'(sp + {8'h00, b0});
            M_SP2: ea = 16'(sp + {b0, b1});
            default: ea = {DIRECT_PAGE, b0};
        endcase
        return ea;
    endfunction

    ctd_dec_s dec_now;
    logic [15:0] ea_now;
    logic [7:0] rel_now;

    assign dec_now = ctd_decode(r.pre, MEM_RDATA);
    assign ea_now = eff_addr(r.dec.mode, r.ob0, r.ob1, r.rg.hx, r.rg.sp);
    assign rel_now = (r.dec.nb == 2'd2) ? r.ob1 : r.ob0;

    always_comb begin
        next_r = r;
        next_r.mem.rd = 1'b0;
        next_r.mem.wr = 1'b0;
        case (r.st)
            S_FETCH: begin
                next_r.mem.addr = r.rg.pc;
                next_r.mem.rd = 1'b1;
                next_r.rg.pc = 16'(r.rg.pc + 16'h0001);
                next_r.st = S_OPC;
            end
            S_OPC: begin
                next_r.dec = dec_now;
                next_r.cnt = 2'd0;
                next_r.st = S_OPR;
                if (!r.pre && MEM_RDATA == OP_PREFIX) begin
                    next_r.pre = 1'b1;
                    next_r.st = S_FETCH;
                end else begin
                    next_r.pre = 1'b0;
                    next_r.ill = (dec_now.kind == K_ILL);
                    case (dec_now.kind)
                        K_TSTA: begin
                            next_r.rg.condition_flags = nz_flags(r.rg.condition_flags,
                                r.rg.acc);
                            next_r.st = S_FETCH;
                        end
                        K_TSTX: begin
                            next_r.rg.condition_flags = nz_flags(r.rg.condition_flags,
                                r.rg.hx[7:0]);
                            next_r.st = S_FETCH;
                        end
                        K_TXA: begin
                            next_r.rg.acc = r.rg.hx[7:0];
                            next_r.st = S_FETCH;
                        end
                        K_TSX: begin
                            next_r.rg.hx = 16'(r.rg.sp + 16'h0001);
                            next_r.st = S_XFER;
                        end
                        K_TXS: begin
                            next_r.rg.sp = 16'(r.rg.hx - 16'h0001);
                            next_r.st = S_XFER;
                        end
                        K_ILL: next_r.st = S_FETCH;
                        default: next_r.st = S_OPR;
                    endcase
                end
            end
            S_OPR: begin
                if (r.cnt < r.dec.nb) begin
                    next_r.mem.addr = r.rg.pc;
                    next_r.mem.rd = 1'b1;
                    next_r.rg.pc = 16'(r.rg.pc + 16'h0001);
                    next_r.st = S_OPRD;
                end else begin
                    next_r.st = S_ADDR;
                end
            end
            S_OPRD: begin
                if (r.cnt == 2'd0) begin
                    next_r.ob0 = MEM_RDATA;
                end else begin
                    next_r.ob1 = MEM_RDATA;
                end
                next_r.cnt = 2'(r.cnt + 2'd1);
                next_r.st = S_OPR;
            end
            S_ADDR: begin
                if (r.dec.mode == M_IMD) begin
                    next_r.mem.addr = {DIRECT_PAGE, r.ob1};
                    next_r.mem.wdata = r.ob0;
                    next_r.mem.wr = 1'b1;
                    next_r.rg.condition_flags = nz_flags(r.rg.condition_flags, r.ob0);
                    next_r.st = S_FETCH;
                end else begin
                    next_r.mem.addr = ea_now;
                    next_r.mem.rd = 1'b1;
                    if (r.dec.mode == M_IXPD) begin
                        next_r.rg.hx = 16'(r.rg.hx + 16'h0001);
                    end
                    next_r.st = S_DATA;
                end
            end
            S_DATA: begin
                next_r.st = S_FETCH;
                if (r.dec.mode == M_IXP || r.dec.mode == M_IX1P) begin
                    next_r.rg.hx = 16'(r.rg.hx + 16'h0001);
                end
                case (r.dec.kind)
                    K_TST: next_r.rg.condition_flags = nz_flags(r.rg.condition_flags,
                        MEM_RDATA);
                    K_LDA: begin
                        next_r.rg.acc = MEM_RDATA;
                        next_r.rg.condition_flags = nz_flags(r.rg.condition_flags,
                            MEM_RDATA);
                    end
                    K_CBEQ: begin
                        if (MEM_RDATA == r.rg.acc) begin
                            next_r.rg.pc = 16'(r.rg.pc + {{8{rel_now[7]}}, rel_now});
                        end
                    end
                    K_MOV: begin
                        next_r.mem.wdata = MEM_RDATA;
                        next_r.mem.wr = 1'b1;
                        next_r.rg.condition_flags = nz_flags(r.rg.condition_flags,
                            MEM_RDATA);
                        if (r.dec.mode == M_DIXP) begin
                            next_r.mem.addr = r.rg.hx;
                            next_r.rg.hx = 16'(r.rg.hx + 16'h0001);
                        end else if (r.dec.mode == M_DD) begin
                            next_r.mem.addr = {DIRECT_PAGE, r.ob1};
                        end else begin
                            next_r.mem.addr = {DIRECT_PAGE, r.ob0};
                        end
                    end
                    default: next_r.st = S_FETCH;
                endcase
            end
            S_XFER: next_r.st = S_FETCH;
            default: next_r.st = S_FETCH;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            r <= STATE_RESET;
        end else if (CE) begin
            r <= next_r;
        end
    end

    assign MEM_REQ = r.mem;
    assign REGS = r.rg;
    assign ILLEGAL = r.ill;

    AST_TSTA_FLAGS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CE && r.st == S_OPC && !r.pre && MEM_RDATA == OP_TST_A) |=>
        (!r.rg.condition_flags[FLAG_V] && r.rg.condition_flags[FLAG_N] == $past(r.rg.acc[7])
        && r.rg.condition_flags[FLAG_C] == $past(r.rg.condition_flags[FLAG_C])
        && r.rg.acc == $past(r.rg.acc)))
        else $error("accumulator test flags wrong");
    AST_PREFIX: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CE && r.st == S_OPC && !r.pre && MEM_RDATA == OP_PREFIX) |=>
        (r.pre && r.st == S_FETCH))
        else $error("prefix byte not taken");
    AST_POSTINC: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CE && r.st == S_DATA && r.dec.mode == M_IXP) |=> (r.rg.hx == 16'($past(r.rg.hx) + 1)))
        else $error("index not incremented after access");
    AST_SP1_ADDR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CE && r.st == S_ADDR && r.dec.mode == M_SP1) |=>
        (MEM_REQ.rd && MEM_REQ.addr == 16'($past(r.rg.sp) + $past(r.ob0))))
        else $error("stack byte offset address wrong");
    AST_IMD_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CE && r.st == S_ADDR && r.dec.mode == M_IMD) |=>
        (MEM_REQ.wr && MEM_REQ.addr == {DIRECT_PAGE, $past(r.ob1)}
        && MEM_REQ.wdata == $past(r.ob0)))
        else $error("immediate move write wrong");
    AST_EXT_ADDR: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CE && r.st == S_ADDR && r.dec.mode == M_EXT) |=>
        (MEM_REQ.addr == {$past(r.ob0), $past(r.ob1)}))
        else $error("extended address wrong");
    AST_TSX: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CE && r.st == S_OPC && !r.pre && MEM_RDATA == OP_STACK_TO_INDEX) |=>
        (r.rg.hx == 16'($past(r.rg.sp) + 1) && r.rg.condition_flags ==
        $past(r.rg.condition_flags) && r.st == S_XFER))
        else $error("stack to index transfer wrong");
    AST_XFER_WAIT: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CE && r.st == S_XFER) |=> (r.st == S_FETCH && !MEM_REQ.rd && !MEM_REQ.wr))
        else $error("transfer wait cycle wrong");
    AST_TXS: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CE && r.st == S_OPC && !r.pre && MEM_RDATA == OP_INDEX_TO_STACK) |=>
        (r.rg.sp == 16'($past(r.rg.hx) - 1)))
        else $error("index to stack transfer wrong");
    AST_TXA: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
        (CE && r.st == S_OPC && !r.pre && MEM_RDATA == OP_INDEX_LOW_TO_ACC) |=>
        (r.rg.acc == $past(r.rg.hx[7:0]) && r.st == S_FETCH
        && r.rg.condition_flags == $past(r.rg.condition_flags)))
        else $error("index low to accumulator wrong");
endmodule
`default_nettype wire

// *** core/ctd_pkg.sv ***
// Shared types, constants and decode table for the test and transfer execute block.
package ctd_pkg;
    localparam logic [7:0] OP_PREFIX = 8'h9E;
    localparam logic [7:0] OP_TST_DIR = 8'h3D;
    localparam logic [7:0] OP_TST_A = 8'h4D;
    localparam logic [7:0] OP_TST_X = 8'h5D;
    localparam logic [7:0] OP_TST_IX1 = 8'h6D;
    localparam logic [7:0] OP_TST_IX = 8'h7D;
    localparam logic [7:0] OP_STACK_TO_INDEX = 8'h95;
    localparam logic [7:0] OP_INDEX_TO_STACK = 8'h94;
    localparam logic [7:0] OP_INDEX_LOW_TO_ACC = 8'h9F;
    localparam logic [7:0] OP_LDA_EXT = 8'hC6;
    localparam logic [7:0] OP_LDA_IX2 = 8'hD6;
    localparam logic [7:0] OP_CMPBR_DIR = 8'h31;
    localparam logic [7:0] OP_CMPBR_IX1P = 8'h61;
    localparam logic [7:0] OP_CMPBR_IXP = 8'h71;
    localparam logic [7:0] OP_MOV_DD = 8'h4E;
    localparam logic [7:0] OP_MOV_DIXP = 8'h5E;
    localparam logic [7:0] OP_MOV_IMD = 8'h6E;
    localparam logic [7:0] OP_MOV_IXPD = 8'h7E;
    localparam int FLAG_V = 7;
    localparam int FLAG_H = 4;
    localparam int FLAG_I = 3;
    localparam int FLAG_N = 2;
    localparam int FLAG_Z = 1;
    localparam int FLAG_C = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h68;
    localparam logic [15:0] SP_RESET = 16'h00FF;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] DIRECT_PAGE = 8'h00;

    typedef enum logic [3:0] {
        M_INH, M_DIR, M_EXT, M_IX, M_IX1, M_IX2, M_SP1, M_SP2,
        M_IXP, M_IX1P, M_DD, M_DIXP, M_IXPD, M_IMD
    } ctd_mode_e;
    typedef enum logic [3:0] {
        K_ILL, K_TST, K_TSTA, K_TSTX, K_LDA, K_CBEQ, K_MOV, K_TSX, K_TXS, K_TXA
    } ctd_kind_e;
    typedef struct packed {
        ctd_kind_e kind;
        ctd_mode_e mode;
        logic [1:0] nb;
    } ctd_dec_s;
    typedef struct packed {
        logic [15:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } ctd_mem_req_s;
    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] sp;
        logic [15:0] hx;
        logic [7:0] acc;
        logic [7:0] condition_flags;
    } ctd_regs_s;

    function automatic ctd_dec_s ctd_decode(input logic pre, input logic [7:0] op);
        ctd_dec_s d;
        d = '{K_ILL, M_INH, 2'd0};
        if (pre) begin
            case (op)
                OP_TST_IX1: d = '{K_TST, M_SP1, 2'd1};
                OP_CMPBR_IX1P: d = '{K_CBEQ, M_SP1, 2'd2};
                OP_LDA_IX2: d = '{K_LDA, M_SP2, 2'd2};
                default: d = '{K_ILL, M_INH, 2'd0};
            endcase
        end else begin
            case (op)
                OP_TST_DIR: d = '{K_TST, M_DIR, 2'd1};
                OP_TST_A: d = '{K_TSTA, M_INH, 2'd0};
                OP_TST_X: d = '{K_TSTX, M_INH, 2'd0};
                OP_TST_IX1: d = '{K_TST, M_IX1, 2'd1};
                OP_TST_IX: d = '{K_TST, M_IX, 2'd0};
                OP_STACK_TO_INDEX: d = '{K_TSX, M_INH, 2'd0};
                OP_INDEX_TO_STACK: d = '{K_TXS, M_INH, 2'd0};
                OP_INDEX_LOW_TO_ACC: d = '{K_TXA, M_INH, 2'd0};
                OP_LDA_EXT: d = '{K_LDA, M_EXT, 2'd2};
                OP_LDA_IX2: d = '{K_LDA, M_IX2, 2'd2};
                OP_CMPBR_DIR: d = '{K_CBEQ, M_DIR, 2'd2};
                OP_CMPBR_IX1P: d = '{K_CBEQ, M_IX1P, 2'd2};
                OP_CMPBR_IXP: d = '{K_CBEQ, M_IXP, 2'd1};
                OP_MOV_DD: d = '{K_MOV, M_DD, 2'd2};
                OP_MOV_DIXP: d = '{K_MOV, M_DIXP, 2'd1};
                OP_MOV_IMD: d = '{K_MOV, M_IMD, 2'd2};
                OP_MOV_IXPD: d = '{K_MOV, M_IXPD, 2'd1};
                default: d = '{K_ILL, M_INH, 2'd0};
            endcase
        end
        return d;
    endfunction
endpackage

// *** test/ctd_core_tb.sv ***
// Self-checking bench for the test and transfer execute block.
`timescale 1ns/1ps
`default_nettype none
module ctd_core_tb;
    import ctd_pkg::*;
    typedef struct packed {
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
        logic chk;
        logic [48:0] st;
        int gap;
    } ctd_exp_s;
    logic SYS_CLK = 1'b0;
    logic RESETN = 1'b0;
    logic CE = 1'b1;
    logic [7:0] MEM_RDATA = 8'hA5;
    ctd_mem_req_s MEM_REQ;
    ctd_regs_s REGS;
    logic ILLEGAL;
    logic [7:0] mem [0:65535];
    logic [7:0] sh [0:65535];
    ctd_exp_s exp_q [$];
    int failures = 0;
    int tests_run = 0;
    int gapc = 0;
    int gap_next = 0;
    logic [15:0] ppc, sp, hx;
    logic [7:0] acc, fl;
    logic ill;
    wire logic [24:0] bus_now = {MEM_REQ.wr, MEM_REQ.addr, MEM_REQ.wr ? MEM_REQ.wdata : 8'h00};
    wire logic [48:0] regs_now = {REGS.sp, REGS.hx, REGS.acc, REGS.condition_flags, ILLEGAL};

    always #5 SYS_CLK = ~SYS_CLK;

    ctd_core ctd_core_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .CE(CE), .MEM_REQ(MEM_REQ),
        .MEM_RDATA(MEM_RDATA), .REGS(REGS), .ILLEGAL(ILLEGAL));

    task automatic check(input logic [63:0] got, input logic [63:0] want);
        tests_run++;
        if (got !== want) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic cmp_req(input logic [24:0] got, input logic [24:0] want);
        check(64'(got), 64'(want));
    endtask
    task automatic cmp_regs(input logic [48:0] got, input logic [48:0] want);
        check(64'(got), 64'(want));
    endtask
    task automatic cmp_gap(input int got, input int want);
        check(64'(got), 64'(want));
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Expected model: program bytes, data reads and writes in bus order.
    task automatic push(input logic w, input logic [15:0] a, input logic [7:0] d,
        input logic c, input int g);
        exp_q.push_back('{w, a, d, c, {sp, hx, acc, fl, ill}, g});
    endtask
    task automatic put(input logic [7:0] b, input logic c, input int g);
        mem[ppc] = b;
        sh[ppc] = b;
        push(1'b0, ppc, 8'h00, c, c ? gap_next : 0);
        if (c) begin
            ill = 1'b0;
            gap_next = g;
        end
        ppc = ppc + 16'h0001;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] want, output logic [7:0] v);
        if ($isunknown(sh[a])) begin
            mem[a] = want;
            sh[a] = want;
        end
        v = sh[a];
        push(1'b0, a, 8'h00, 1'b0, 0);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        sh[a] = v;
        push(1'b1, a, v, 1'b0, 0);
    endtask
    task automatic nz(input logic [7:0] v);
        fl[FLAG_N] = v[7];
        fl[FLAG_Z] = (v == 8'h00);
        fl[FLAG_V] = 1'b0;
    endtask
    task automatic br(input logic [7:0] v, input logic [7:0] r);
        if (v == acc) ppc = ppc + {{8{r[7]}}, r};
    endtask

    task automatic exec(input int sel);
        logic [7:0] d, e, f, v, r;
        d = {1'b1, 7'($urandom)};
        e = {1'b0, 7'($urandom)} | 8'h02;
        f = 8'($urandom);
        r = 8'($urandom_range(1, 4));
        case (sel)
            0: begin put(OP_STACK_TO_INDEX, 1, 3); hx = sp + 16'h0001; end
            1: begin put(OP_INDEX_TO_STACK, 1, 3); sp = hx - 16'h0001; end
            2: begin put(OP_INDEX_LOW_TO_ACC, 1, 2); acc = hx[7:0]; end
            3: begin put(OP_TST_A, 1, 2); nz(acc); end
            4: begin put(OP_TST_X, 1, 0); nz(hx[7:0]); end
            5: begin put(OP_TST_DIR, 1, 7); put(d, 0, 0); rd({8'h00, d}, e, v); nz(v); end
            6: begin put(OP_TST_IX1, 1, 0); put(e, 0, 0); rd(hx + 16'(e), f, v); nz(v); end
            7: begin put(OP_TST_IX, 1, 0); rd(hx, f, v); nz(v); end
            8: begin
                put(OP_PREFIX, 1, 0); put(OP_TST_IX1, 0, 0); put(e, 0, 0);
                rd(sp + 16'(e), f, v); nz(v);
            end
            9: begin
                put(OP_LDA_EXT, 1, 0); put(e, 0, 0); put(f, 0, 0);
                rd({e, f}, d, acc); nz(acc);
            end
            10: begin
                put(OP_LDA_IX2, 1, 0); put(e, 0, 0); put(f, 0, 0);
                rd(hx + {e, f}, d, acc); nz(acc);
            end
            11: begin
                put(OP_PREFIX, 1, 0); put(OP_LDA_IX2, 0, 0); put(e, 0, 0); put(f, 0, 0);
                rd(sp + {e, f}, d, acc); nz(acc);
            end
            12: begin
                put(OP_CMPBR_DIR, 1, 0); put(d, 0, 0); put(r, 0, 0);
                rd({8'h00, d}, acc, v); br(v, r);
            end
            13: begin
                put(OP_CMPBR_IX1P, 1, 0); put(e, 0, 0); put(r, 0, 0);
                rd(hx + 16'(e), acc, v); hx++; br(v, r);
            end
            14: begin put(OP_CMPBR_IXP, 1, 0); put(r, 0, 0); rd(hx, f, v); hx++; br(v, r); end
            15: begin
                put(OP_PREFIX, 1, 0); put(OP_CMPBR_IX1P, 0, 0); put(e, 0, 0); put(r, 0, 0);
                rd(sp + 16'(e), acc, v); br(v, r);
            end
            16: begin
                put(OP_MOV_DD, 1, 0); put(d, 0, 0); put(e | 8'h80, 0, 0);
                rd({8'h00, d}, f, v); wr({8'h00, e | 8'h80}, v); nz(v);
            end
            17: begin
                put(OP_MOV_DIXP, 1, 0); put(d, 0, 0);
                rd({8'h00, d}, f, v); wr(hx, v); hx++; nz(v);
            end
            18: begin put(OP_MOV_IMD, 1, 0); put(f, 0, 0); put(d, 0, 0); wr({8'h00, d}, f); nz(f); end
            19: begin
                put(OP_MOV_IXPD, 1, 0); put(d, 0, 0);
                rd(hx, f, v); hx++; wr({8'h00, d}, v); nz(v);
            end
            default: begin put(8'hAB, 1, 0); ill = 1'b1; end
        endcase
    endtask

    // Memory answers within the cycle in which a read is shown; otherwise the data lines wander.
    always @(posedge SYS_CLK) begin
        #1;
        if (RESETN) MEM_RDATA = MEM_REQ.rd ? mem[MEM_REQ.addr] : ~MEM_RDATA;
    end
    always @(posedge SYS_CLK) begin
        CE <= #1 (RESETN ? ($urandom_range(0, 3) != 0) : 1'b1);
    end

    always @(posedge SYS_CLK) begin
        ctd_exp_s e;
        if (RESETN && CE) begin
            gapc = gapc + 1;
            if (MEM_REQ.wr) mem[MEM_REQ.addr] = MEM_REQ.wdata;
            if ((MEM_REQ.rd || MEM_REQ.wr) && exp_q.size() > 0) begin
                e = exp_q.pop_front();
                cmp_req(bus_now, {e.wr, e.addr, e.data});
                if (e.chk) begin
                    cmp_regs(regs_now, e.st);
                    cmp_req({1'b0, REGS.pc, 8'h00}, {1'b0, 16'(e.addr + 16'h0001), 8'h00});
                    if (e.gap != 0) cmp_gap(gapc, e.gap);
                    gapc = 0;
                end
            end
        end
    end

    initial begin
        #150000;
        failures++;
        test_done();
    end

    initial begin
        int n;
        void'($urandom(32'hFA87));
        ppc = PC_RESET;
        sp = SP_RESET;
        hx = 16'h0000;
        acc = 8'h00;
        fl = FLAGS_RESET;
        ill = 1'b0;
        for (n = 0; ppc < 16'h0068; n++) exec(n < 21 ? n : $urandom_range(0, 20));
        repeat (12) @(posedge SYS_CLK);
        cmp_regs(regs_now, {SP_RESET, 16'h0000, 8'h00, FLAGS_RESET, 1'b0});
        cmp_req(bus_now, 25'h0000000);
        #1 RESETN = 1'b1;
        n = 0;
        while (exp_q.size() > 0 && n < 10000) begin
            @(posedge SYS_CLK);
            n++;
        end
        if (exp_q.size() != 0) failures++;
        test_done();
    end
endmodule
`default_nettype wire
